// *** hdl/hdcra_pkg.sv ***
package hdcra_pkg;
   // ==========================================
   // Register addresses
   localparam logic [31:0] HDCRA_ADDR_HCS = 32'hE000EDF0;
   localparam logic [31:0] HDCRA_ADDR_SEL = 32'hE000EDF4;
   localparam logic [31:0] HDCRA_ADDR_DATA = 32'hE000EDF8;

   // ==========================================
   // Halt control status fields
   localparam int HDCRA_BIT_HALTED = 17;
   localparam int HDCRA_BIT_READY = 16;
   localparam int HDCRA_BIT_IMPRECISE = 5;
   localparam int HDCRA_BIT_MASK = 3;
   localparam int HDCRA_BIT_STEP = 2;
   localparam int HDCRA_BIT_HALT = 1;
   localparam int HDCRA_BIT_ENABLE = 0;
   localparam logic [15:0] HDCRA_WRITE_KEY = 16'hA05F;
   localparam int HDCRA_KEY_LSB = 16;

   // ==========================================
   // Core register selector fields
   localparam int HDCRA_BIT_DIR = 16;
   localparam int HDCRA_SEL_W = 7;
   localparam int HDCRA_SEL_W_NOFP = 5;
   localparam logic HDCRA_HAS_FP = 1'b1;
   localparam logic [6:0] HDCRA_SEL_R12 = 7'h0C;
   localparam logic [6:0] HDCRA_SEL_SP = 7'h0D;
   localparam logic [6:0] HDCRA_SEL_LR = 7'h0E;
   localparam logic [6:0] HDCRA_SEL_RESUME = 7'h0F;
   localparam logic [6:0] HDCRA_SEL_PSR = 7'h10;
   localparam logic [6:0] HDCRA_SEL_MSP = 7'h11;
   localparam logic [6:0] HDCRA_SEL_PSP = 7'h12;
   localparam logic [6:0] HDCRA_SEL_SPECIAL = 7'h14;
   localparam logic [6:0] HDCRA_SEL_FPSC = 7'h21;
   localparam logic [6:0] HDCRA_SEL_S0 = 7'h40;
   localparam logic [6:0] HDCRA_SEL_S31 = 7'h5F;

   // ==========================================
   // Reset values and sizes
   localparam logic [31:0] HDCRA_WORD_RESET = 32'h00000000;
   localparam int HDCRA_EXT_IRQS = 8;

   typedef enum logic [1:0] {XF_IDLE, XF_LOCAL, XF_CORE} hdcra_xfer_e;
endpackage : hdcra_pkg

// *** hdl/hdcra_sel_decode.sv ***
`timescale 1ns/1ps
module hdcra_sel_decode (
   input wire logic [hdcra_pkg::HDCRA_SEL_W-1:0] sel,
   output logic sel_valid,
   output logic sel_resume
);
   import hdcra_pkg::*;

   logic [HDCRA_SEL_W-1:0] eff;

   // ==========================================
   // Select decode
   always_comb begin
      eff = sel;
      if (!HDCRA_HAS_FP) begin
         eff = {2'b00, sel[HDCRA_SEL_W_NOFP-1:0]};
      end
      sel_resume = (eff == HDCRA_SEL_RESUME);
      sel_valid = (eff <= HDCRA_SEL_PSP)
         || (eff == HDCRA_SEL_SPECIAL)
         || (HDCRA_HAS_FP && (eff == HDCRA_SEL_FPSC))
         || (HDCRA_HAS_FP && (eff >= HDCRA_SEL_S0) && (eff <= HDCRA_SEL_S31));
   end
endmodule : hdcra_sel_decode

// *** hdl/hdcra_resume_addr.sv ***
`timescale 1ns/1ps
module hdcra_resume_addr (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic debug_entry,
   input wire logic entry_is_bkpt,
   input wire logic [31:0] bkpt_addr,
   input wire logic [31:0] next_addr,
   input wire logic wr_en,
   input wire logic [31:0] wdata,
   output logic [31:0] resume_address
);
   import hdcra_pkg::*;

   logic [31:0] addr_reg;
   logic [31:0] addr_next;

   // ==========================================
   // Resume address capture
   always_comb begin
      addr_next = addr_reg;
      if (debug_entry) begin
         addr_next = entry_is_bkpt ? bkpt_addr : next_addr;
      end else if (wr_en) begin
         addr_next = wdata;
      end
      addr_next[0] = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_reg <= HDCRA_WORD_RESET;
      end else if (ce) begin
         addr_reg <= addr_next;
      end
   end

   assign resume_address = addr_reg;

   chk_resume_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !resume_address[0]) else $error("resume address bit 0 not zero");
   chk_resume_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && debug_entry && entry_is_bkpt |=> resume_address[31:1] == $past(bkpt_addr[31:1]))
      else $error("breakpoint address not captured");
endmodule : hdcra_resume_addr

// *** hdl/hdcra_core.sv ***
`timescale 1ns/1ps
module hdcra_core (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic local_rst,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic acc_from_dap,
   input wire logic [31:0] acc_addr,
   input wire logic [31:0] acc_wdata,
   output logic [31:0] acc_rdata,
   output logic acc_rvalid,
   input wire logic core_halted,
   input wire logic debug_entry,
   input wire logic entry_is_bkpt,
   input wire logic [31:0] bkpt_addr,
   input wire logic [31:0] next_addr,
   output logic [31:0] resume_address,
   output logic halt_req,
   output logic step_enable,
   output logic imprecise_entry_req,
   output logic xfer_req,
   output logic xfer_write,
   output logic [hdcra_pkg::HDCRA_SEL_W-1:0] xfer_sel,
   output logic [31:0] xfer_wdata,
   input wire logic xfer_done,
   input wire logic [31:0] xfer_rdata,
   input wire logic pendable_service_call_in,
   input wire logic system_tick_interrupt_in,
   input wire logic [hdcra_pkg::HDCRA_EXT_IRQS-1:0] ext_irq_in,
   input wire logic nmi_in,
   output logic pendable_service_call_out,
   output logic system_tick_interrupt_out,
   output logic [hdcra_pkg::HDCRA_EXT_IRQS-1:0] ext_irq_out,
   output logic nmi_out
);
   import hdcra_pkg::*;

   // ==========================================
   // Access decode
   logic wr_hcs;
   logic wr_sel;
   logic wr_data;
   logic rd_any;
   logic key_ok;
   logic sel_accept;

   assign wr_hcs = acc_valid && acc_write && (acc_addr == HDCRA_ADDR_HCS);
   assign wr_sel = acc_valid && acc_write && (acc_addr == HDCRA_ADDR_SEL);
   assign wr_data = acc_valid && acc_write && (acc_addr == HDCRA_ADDR_DATA);
   assign rd_any = acc_valid && !acc_write;
   assign key_ok = (acc_wdata[31:HDCRA_KEY_LSB] == HDCRA_WRITE_KEY);

   // ==========================================
   // Halt control state
   logic halting_debug_enable_reg;
   logic halting_debug_enable_next;
   logic halt_reg;
   logic halt_next;
   logic step_reg;
   logic step_next;
   logic debug_irq_mask_reg;
   logic debug_irq_mask_next;
   logic imprecise_entry_req_reg;
   logic imprecise_entry_req_next;
   logic ctl_wr;

   assign ctl_wr = wr_hcs && key_ok;

   always_comb begin
      halting_debug_enable_next = halting_debug_enable_reg;
      halt_next = halt_reg;
      step_next = step_reg;
      debug_irq_mask_next = debug_irq_mask_reg;
      imprecise_entry_req_next = imprecise_entry_req_reg;
      if (ctl_wr) begin
         if (acc_from_dap) begin
            halting_debug_enable_next = acc_wdata[HDCRA_BIT_ENABLE];
         end
         halt_next = acc_wdata[HDCRA_BIT_HALT];
         debug_irq_mask_next = acc_wdata[HDCRA_BIT_MASK];
         if (acc_wdata[HDCRA_BIT_STEP]) begin
            step_next = 1'b1;
         end
         if (acc_wdata[HDCRA_BIT_IMPRECISE]) begin
            imprecise_entry_req_next = 1'b1;
         end
      end
      if (debug_entry) begin
         halt_next = 1'b1;
      end
      if (local_rst) begin
         halt_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         halting_debug_enable_reg <= 1'b0;
         halt_reg <= 1'b0;
         step_reg <= 1'b0;
         debug_irq_mask_reg <= 1'b0;
         imprecise_entry_req_reg <= 1'b0;
      end else if (ce) begin
         halting_debug_enable_reg <= halting_debug_enable_next;
         halt_reg <= halt_next;
         step_reg <= step_next;
         debug_irq_mask_reg <= debug_irq_mask_next;
         imprecise_entry_req_reg <= imprecise_entry_req_next;
      end
   end

   assign halt_req = halting_debug_enable_reg && halt_reg;
   assign step_enable = halting_debug_enable_reg && step_reg;
   assign imprecise_entry_req = halting_debug_enable_reg && imprecise_entry_req_reg;

   // ==========================================
   // Interrupt masking
   logic mask_on;

   assign mask_on = halting_debug_enable_reg && debug_irq_mask_reg;
   assign pendable_service_call_out = pendable_service_call_in && !mask_on;
   assign system_tick_interrupt_out = system_tick_interrupt_in && !mask_on;
   assign nmi_out = nmi_in;

   genvar gi;
   generate
      for (gi = 0; gi < HDCRA_EXT_IRQS; gi++) begin : g_ext_mask
         assign ext_irq_out[gi] = ext_irq_in[gi] && !mask_on;
      end
   endgenerate

   // ==========================================
   // Transfer control
   hdcra_xfer_e xf_reg;
   hdcra_xfer_e xf_next;
   logic [HDCRA_SEL_W-1:0] sel_reg;
   logic [HDCRA_SEL_W-1:0] sel_next;
   logic dir_reg;
   logic dir_next;
   logic ready_reg;
   logic ready_next;
   logic [31:0] data_word_reg;
   logic [31:0] data_word_next;
   logic sel_valid;
   logic sel_resume;
   logic resume_wr;

   hdcra_sel_decode u_decode (
      .sel(acc_wdata[HDCRA_SEL_W-1:0]),
      .sel_valid(sel_valid),
      .sel_resume(sel_resume)
   );

   assign sel_accept = wr_sel && core_halted && (xf_reg == XF_IDLE);

   always_comb begin
      xf_next = xf_reg;
      sel_next = sel_reg;
      dir_next = dir_reg;
      ready_next = ready_reg;
      data_word_next = data_word_reg;
      resume_wr = 1'b0;
      if (wr_data) begin
         data_word_next = acc_wdata;
      end
      unique case (xf_reg)
         XF_IDLE: begin
            if (sel_accept) begin
               sel_next = acc_wdata[HDCRA_SEL_W-1:0];
               dir_next = acc_wdata[HDCRA_BIT_DIR];
               ready_next = 1'b0;
               if (sel_valid && !sel_resume) begin
                  xf_next = XF_CORE;
               end else begin
                  xf_next = XF_LOCAL;
               end
            end
         end
         XF_LOCAL: begin
            if (sel_reg == HDCRA_SEL_RESUME) begin
               if (dir_reg) begin
                  resume_wr = 1'b1;
               end else begin
                  data_word_next = resume_address;
               end
            end
            ready_next = 1'b1;
            xf_next = XF_IDLE;
         end
         XF_CORE: begin
            if (xfer_done) begin
               if (!dir_reg) begin
                  data_word_next = xfer_rdata;
               end
               ready_next = 1'b1;
               xf_next = XF_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         xf_reg <= XF_IDLE;
         sel_reg <= '0;
         dir_reg <= 1'b0;
         ready_reg <= 1'b0;
         data_word_reg <= HDCRA_WORD_RESET;
      end else if (ce) begin
         xf_reg <= xf_next;
         sel_reg <= sel_next;
         dir_reg <= dir_next;
         ready_reg <= ready_next;
         data_word_reg <= data_word_next;
      end
   end

   assign xfer_req = (xf_reg == XF_CORE);
   assign xfer_write = dir_reg;
   assign xfer_sel = sel_reg;
   assign xfer_wdata = data_word_reg;

   hdcra_resume_addr u_resume (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .debug_entry(debug_entry),
      .entry_is_bkpt(entry_is_bkpt),
      .bkpt_addr(bkpt_addr),
      .next_addr(next_addr),
      .wr_en(resume_wr),
      .wdata(data_word_reg),
      .resume_address(resume_address)
   );

   // ==========================================
   // Read data
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   always_comb begin
      rdata_next = rdata_reg;
      rvalid_next = rd_any;
      if (rd_any) begin
         rdata_next = '0;
         if (acc_addr == HDCRA_ADDR_HCS) begin
            rdata_next[HDCRA_BIT_HALTED] = core_halted;
            rdata_next[HDCRA_BIT_READY] = core_halted && ready_reg;
            rdata_next[HDCRA_BIT_IMPRECISE] = imprecise_entry_req_reg;
            rdata_next[HDCRA_BIT_MASK] = mask_on;
            rdata_next[HDCRA_BIT_STEP] = step_enable;
            rdata_next[HDCRA_BIT_HALT] = halt_req;
            rdata_next[HDCRA_BIT_ENABLE] = halting_debug_enable_reg;
         end else if (acc_addr == HDCRA_ADDR_DATA) begin
            rdata_next = data_word_reg;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= HDCRA_WORD_RESET;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign acc_rdata = rdata_reg;
   assign acc_rvalid = rvalid_reg;

   // ==========================================
   // Checks
   chk_halted_readback: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && rd_any && acc_addr == HDCRA_ADDR_HCS
      |=> acc_rvalid && acc_rdata[HDCRA_BIT_HALTED] == $past(core_halted))
      else $error("halted status bit wrong");
   chk_ready_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && sel_accept |=> !ready_reg) else $error("ready not cleared");
   chk_ready_core_done: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && xf_reg == XF_CORE && xfer_done |=> ready_reg && xf_reg == XF_IDLE)
      else $error("ready not set after transfer");
   chk_imprecise_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
      imprecise_entry_req_reg |=> imprecise_entry_req_reg)
      else $error("imprecise bit cleared by a write");
   chk_key_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && wr_hcs && !key_ok && !debug_entry && !local_rst
      |=> $stable(halt_reg) && $stable(debug_irq_mask_reg))
      else $error("unkeyed write took effect");
   chk_enable_sw: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && wr_hcs && !acc_from_dap |=> $stable(halting_debug_enable_reg))
      else $error("software changed debug enable");
   chk_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
      mask_on |-> !pendable_service_call_out && !system_tick_interrupt_out
      && ext_irq_out == '0 && nmi_out == nmi_in) else $error("interrupt mask wrong");
   chk_halt_local: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && local_rst |=> !halt_reg) else $error("halt kept over local reset");
   chk_step_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && ctl_wr && acc_wdata[HDCRA_BIT_STEP] |=> step_reg)
      else $error("step bit not set");
   chk_core_request: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && sel_accept && sel_valid && !sel_resume
      |=> xfer_req && xfer_write == $past(acc_wdata[HDCRA_BIT_DIR]))
      else $error("transfer not started");
   chk_halt_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ce && ctl_wr && !debug_entry && !local_rst
      |=> halt_reg == $past(acc_wdata[HDCRA_BIT_HALT])) else $error("halt bit not written");
endmodule : hdcra_core

// *** verification/hdcra_debugger.sv ***
`timescale 1ns/1ps
// ==========================================
// Debugger side of the register port
module hdcra_debugger (
   input wire logic ref_clk,
   output logic acc_valid,
   output logic acc_write,
   output logic acc_from_dap,
   output logic [31:0] acc_addr,
   output logic [31:0] acc_wdata,
   input wire logic [31:0] acc_rdata,
   input wire logic acc_rvalid
);
   import hdcra_pkg::*;

   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_from_dap = 1'b1;
      acc_addr = 32'h00000000;
      acc_wdata = 32'h00000000;
   end

   // One access, held for the taken edge, then released
   task automatic access(input logic wr, input logic debug_access_port, input logic [31:0] addr,
                         input logic [31:0] data, output logic [31:0] rd);
      @(posedge ref_clk);
      #2;
      acc_valid = 1'b1;
      acc_write = wr;
      acc_from_dap = debug_access_port;
      acc_addr = addr;
      acc_wdata = data;
      @(posedge ref_clk);
      #2;
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_addr = ~addr;
      acc_wdata = ~data;
      rd = (wr || acc_rvalid === 1'b1) ? acc_rdata : 32'hXXXXXXXX;
   endtask : access

   // Control write always carries the key
   task automatic hcs_write(input logic [15:0] low);
      logic [31:0] rd;
      access(1'b1, 1'b1, HDCRA_ADDR_HCS, {HDCRA_WRITE_KEY, low}, rd);
   endtask : hcs_write
endmodule : hdcra_debugger

// *** verification/test_halting_debug_core_reg_access.sv ***
`timescale 1ns/1ps
module test_halting_debug_core_reg_access;
   import hdcra_pkg::*;
   typedef struct {logic [6:0] sel; logic [31:0] data; logic core;} hdcra_row_s;
   logic ref_clk, rst_b, ce, local_rst, acc_valid, acc_write, acc_from_dap, acc_rvalid;
   logic [31:0] acc_addr, acc_wdata, acc_rdata, bkpt_addr, next_addr, resume_address;
   logic [31:0] xfer_wdata, xfer_rdata, rd, exp;
   logic core_halted = 1'b0, debug_entry = 1'b0, entry_is_bkpt, halt_req, step_enable, imp_req;
   logic xfer_req, xfer_write, xfer_done = 1'b0, psc_in, tick_in, nmi_in, psc_out, tick_out;
   logic nmi_out;
   logic [HDCRA_SEL_W-1:0] xfer_sel, last_sel;
   logic [HDCRA_EXT_IRQS-1:0] ext_in, ext_out;
   logic [31:0] core_regs [128];
   int err_total, checks_done, lat, wait_cnt = 0, n_xfer = 0, base;
   hdcra_row_s rows [14];

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   hdcra_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .local_rst(local_rst),
      .acc_valid(acc_valid), .acc_write(acc_write), .acc_from_dap(acc_from_dap),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
      .acc_rvalid(acc_rvalid), .core_halted(core_halted), .debug_entry(debug_entry),
      .entry_is_bkpt(entry_is_bkpt), .bkpt_addr(bkpt_addr), .next_addr(next_addr),
      .resume_address(resume_address), .halt_req(halt_req), .step_enable(step_enable),
      .imprecise_entry_req(imp_req), .xfer_req(xfer_req), .xfer_write(xfer_write),
      .xfer_sel(xfer_sel), .xfer_wdata(xfer_wdata), .xfer_done(xfer_done),
      .xfer_rdata(xfer_rdata), .pendable_service_call_in(psc_in),
      .system_tick_interrupt_in(tick_in), .ext_irq_in(ext_in), .nmi_in(nmi_in),
      .pendable_service_call_out(psc_out), .system_tick_interrupt_out(tick_out),
      .ext_irq_out(ext_out), .nmi_out(nmi_out));

   hdcra_debugger dbg (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_write(acc_write),
      .acc_from_dap(acc_from_dap), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

   // ==========================================
   // Processor model
   assign xfer_rdata = core_regs[xfer_sel];
   always @(posedge ref_clk) begin
      #2;
      debug_entry = halt_req && !core_halted;
      core_halted = halt_req;
      if (xfer_done) begin
         xfer_done = 1'b0;
      end else if (xfer_req === 1'b1) begin
         if (wait_cnt >= lat) begin
            xfer_done = 1'b1;
            wait_cnt = 0;
            n_xfer++;
            last_sel = xfer_sel;
            if (xfer_write) core_regs[xfer_sel] = xfer_wdata;
         end else begin
            wait_cnt++;
         end
      end
   end

   // ==========================================
   // Checks and helpers
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
      checks_done++;
      if ((got & m) !== (e & m)) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic e);
      checks_done++;
      if (got !== e) begin
         err_total++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, e);
      end
   endtask : cmp_bit

   task automatic rdreg(input logic [31:0] a);
      dbg.access(1'b0, 1'b1, a, 32'h00000000, rd);
   endtask : rdreg

   task automatic wr_dap(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      dbg.access(1'b1, 1'b1, a, d, x);
   endtask : wr_dap

   task automatic wait_ready;
      for (int i = 0; i < 30; i++) begin
         rdreg(HDCRA_ADDR_HCS);
         if (rd[HDCRA_BIT_READY] === 1'b1) break;
      end
   endtask : wait_ready

   task automatic conclude;
      $display("Mismatches: %0d, comparisons: %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   initial begin
      #(40 * 6000);
      err_total++;
      conclude();
   end

   // ==========================================
   // Main sequence
   initial begin
      rst_b = 1'b0; ce = 1'b1; local_rst = 1'b0;
      entry_is_bkpt = 1'b1; bkpt_addr = 32'h00001000; next_addr = 32'h00001004;
      psc_in = 1'b1; tick_in = 1'b1; nmi_in = 1'b1; ext_in = 8'hA5;
      lat = 3; err_total = 0; checks_done = 0;
      foreach (core_regs[i]) core_regs[i] = 32'h00000000;
      rows = '{'{7'h00, 32'h11111111, 1'b1}, '{7'h0C, 32'h2222000C, 1'b1},
         '{7'h0D, 32'h20000F00, 1'b1}, '{7'h0E, 32'hFFFFFFF9, 1'b1},
         '{7'h0F, 32'h00001235, 1'b0}, '{7'h10, 32'h01000003, 1'b1},
         '{7'h11, 32'h20000E00, 1'b1}, '{7'h12, 32'h20000D00, 1'b1},
         '{7'h14, 32'h02010301, 1'b1}, '{7'h21, 32'h03C00000, 1'b1},
         '{7'h40, 32'h3F800000, 1'b1}, '{7'h5F, 32'hC0000000, 1'b1},
         '{7'h13, 32'h12345678, 1'b0}, '{7'h7F, 32'h87654321, 1'b0}};
      repeat (3) @(posedge ref_clk);
      #2 rst_b = 1'b1;
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h0003002F);
      rdreg(32'hE000EDFC);
      cmp_word(rd, 32'h00000000, 32'hFFFFFFFF);
      wr_dap(HDCRA_ADDR_HCS, 32'h00000003);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h0000000F);
      dbg.access(1'b1, 1'b0, HDCRA_ADDR_HCS, 32'hA05F0003, rd);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h0000000F);
      base = n_xfer;
      wr_dap(HDCRA_ADDR_SEL, 32'h00000003);
      repeat (5) @(posedge ref_clk);
      cmp_word(32'(n_xfer - base), 32'h00000000, 32'hFFFFFFFF);
      dbg.hcs_write(16'hFFD3);
      repeat (3) @(posedge ref_clk);
      cmp_bit(halt_req, 1'b1);
      cmp_word(resume_address, bkpt_addr, 32'hFFFFFFFF);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00020003, 32'h0002FFDF);
      dbg.hcs_write(16'h000B);
      @(posedge ref_clk);
      cmp_word({psc_out, tick_out, ext_out, nmi_out}, 11'h001, 32'h000007FF);
      #2 psc_in = 1'b0;
      nmi_in = 1'b0;
      ext_in = 8'hFF;
      @(posedge ref_clk);
      cmp_word({psc_out, tick_out, ext_out, nmi_out}, 11'h000, 32'h000007FF);
      dbg.hcs_write(16'h0003);
      psc_in = 1'b1;
      tick_in = 1'b0;
      ext_in = 8'h5A;
      @(posedge ref_clk);
      cmp_word({psc_out, tick_out, ext_out, nmi_out}, 11'h4B4, 32'h000007FF);
      dbg.hcs_write(16'h0007);
      dbg.hcs_write(16'h0003);
      @(posedge ref_clk);
      cmp_bit(step_enable, 1'b1);
      foreach (rows[i]) begin
         wr_dap(HDCRA_ADDR_DATA, rows[i].data);
         base = n_xfer;
         wr_dap(HDCRA_ADDR_SEL, {15'h0000, 1'b1, 9'h000, rows[i].sel});
         rdreg(HDCRA_ADDR_HCS);
         if (rows[i].core) cmp_bit(rd[HDCRA_BIT_READY], 1'b0);
         wait_ready();
         cmp_bit(rd[HDCRA_BIT_READY], 1'b1);
         if (rows[i].sel == HDCRA_SEL_RESUME)
            cmp_word(resume_address, rows[i].data & 32'hFFFFFFFE, 32'hFFFFFFFF);
         wr_dap(HDCRA_ADDR_DATA, 32'h00000000);
         wr_dap(HDCRA_ADDR_SEL, {25'h0000000, rows[i].sel});
         wait_ready();
         rdreg(HDCRA_ADDR_DATA);
         exp = rows[i].core ? rows[i].data :
            (rows[i].sel == HDCRA_SEL_RESUME ? rows[i].data & 32'hFFFFFFFE : 32'h00000000);
         cmp_word(rd, exp, 32'hFFFFFFFF);
         cmp_word(32'(n_xfer - base), rows[i].core ? 32'h2 : 32'h0, 32'hFFFFFFFF);
         if (rows[i].core) cmp_word({25'h0, last_sel}, {25'h0, rows[i].sel}, 32'h7F);
      end
      lat = 8;
      base = n_xfer;
      wr_dap(HDCRA_ADDR_SEL, 32'h00000003);
      wr_dap(HDCRA_ADDR_SEL, 32'h00000005);
      wait_ready();
      cmp_word(32'(n_xfer - base), 32'h00000001, 32'hFFFFFFFF);
      cmp_word({25'h0, last_sel}, 32'h00000003, 32'h7F);
      dbg.hcs_write(16'h0001);
      repeat (2) @(posedge ref_clk);
      cmp_bit(halt_req, 1'b0);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000001, 32'h00020003);
      entry_is_bkpt = 1'b0;
      bkpt_addr = 32'h00003000;
      next_addr = 32'h00002008;
      dbg.hcs_write(16'h0003);
      repeat (3) @(posedge ref_clk);
      cmp_word(resume_address, 32'h00002008, 32'hFFFFFFFF);
      @(posedge ref_clk);
      #2 local_rst = 1'b1;
      @(posedge ref_clk);
      #2 local_rst = 1'b0;
      repeat (2) @(posedge ref_clk);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000005, 32'h00000007);
      dbg.hcs_write(16'h0000);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h0000000E);
      dbg.hcs_write(16'h0023);
      dbg.hcs_write(16'h0003);
      @(posedge ref_clk);
      cmp_bit(imp_req, 1'b1);
      @(posedge ref_clk);
      #2 rst_b = 1'b0;
      repeat (3) @(posedge ref_clk);
      #2 rst_b = 1'b1;
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h0000002F);
      cmp_bit(imp_req, 1'b0);
      ce = 1'b0;
      dbg.hcs_write(16'h0003);
      ce = 1'b1;
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000000, 32'h00000003);
      dbg.hcs_write(16'h0003);
      rdreg(HDCRA_ADDR_HCS);
      cmp_word(rd, 32'h00000003, 32'h00000003);
      conclude();
   end
endmodule : test_halting_debug_core_reg_access
